// ==== core/mte_core.sv ====
// Purpose: instruction timing and execution of an 8-bit core
// Assumes: program word arrives one clock after prog_addr_o changes
// Notes: table read fetches from the address held in acc:tbl pointer
`timescale 1ns/1ps
module mte_core (
	// clock and reset
	input  wire logic                  sys_clk_i,
	input  wire logic                  rst_b_i,
	// program memory
	output logic [mte_pkg::PC_W-1:0]   prog_addr_o,
	input  wire logic [15:0]           prog_data_i,
	// observation
	output logic [7:0]                 acc_o,
	output logic                       carry_o,
	output logic                       zero_o,
	output logic [mte_pkg::PC_W-1:0]   pc_o,
	output logic                       cycle_strobe_o,
	output logic                       discard_o,
	output logic [7:0]                 table_data_o
);
	// how one instruction cycle unfolds
	// - phase counts 0..3 on every clock and wraps, one lap per cycle
	// - all architectural work happens on the edge that ends phase 3
	// - the word on prog_data_i at that edge is the next instruction
	// - prog_addr_o therefore shows the word after the one in ir, except in the table cycle and in the flush after a jump
	// - pc holds the fetch address, one ahead of the executing word
	// - so a call saves pc itself as the place to come back to
	// - the cycle strobe is registered, high in the clock after work
	// - acc, flags, pc and table byte all change on that same edge
	//
	// extra cycles and why they exist
	// - a jump, call or return loads pc with the target
	// - the word already fetched from the old pc is stale then
	// - the flush cycle drops it and fetches the target word
	// - discard_o marks the clock in which the drop becomes visible
	// - a taken skip reuses the same flush path with pc plus one
	// - a write to the program counter low byte is a jump as well
	// - the upper counter bits keep their value on such a write
	//
	// table read
	// - the pointer low byte is parked in the table register
	// - the next instruction is fetched normally in the same cycle
	// - the extra cycle points the bus at the table word instead
	// - the fetched instruction sits idle in ir during that cycle
	// - so a table read costs two cycles and nothing is refetched
	// - the pointer high bits come from the accumulator low bits
	//
	// hazards a user must know
	// - the return stack is four deep and wraps without warning
	// - data memory is not cleared by reset, only written by code
	// - address zero of data memory reads the counter low byte
	// - subtract leaves carry set when no borrow happened
	// - a write of the counter low byte never reaches data memory
	//
	// reset
	// - the reset pin asserts at once and releases through two flops
	// - the core leaves reset in a flush cycle with pc at zero
	// - so the very first cycle shows a discard pulse
	// - no visible output moves until the end of that cycle
	//
	// observation ports
	// - every observed value but the fetch address is read straight from a flip-flop
	// - only the fetch address is a mux of registered values
	// - the mux selects the table pointer only in the table cycle
	// - the discard pulse lasts one clock of one cycle
	// - the strobe lasts one clock and repeats every four clocks
	// all state of the core
	typedef struct packed {
		logic [1:0]                 phase;     // clock within instruction cycle
		mte_pkg::mte_state_t        st;        // sequencer state
		logic [mte_pkg::PC_W-1:0]   pc;        // program counter
		logic [15:0]                ir;        // latched instruction
		logic [7:0]                 acc;       // accumulator
		logic                       c;         // carry flag
		logic                       z;         // zero flag
		logic [mte_pkg::STK_AW-1:0] sp;        // stack pointer
		logic [mte_pkg::PC_W*mte_pkg::STK_DEPTH-1:0] stk; // return stack
		logic [7:0]                 tbl;       // table read result
		logic                       strobe;    // cycle end strobe
		logic                       disc;      // discard indication
	} mte_reg_t;

	mte_reg_t   st_ff;                             // registered state
	mte_reg_t   nxt_st;                            // next state
	logic [7:0] dmem_ff [mte_pkg::DM_DEPTH];       // data memory
	logic       rst_s1_ff;                         // reset sync stage 1
	logic       rst_s2_ff;                         // reset sync stage 2
	logic       dm_we;                             // data write strobe
	logic [5:0] dm_wa;                             // data write address
	logic [7:0] dm_wd;                             // data write value

	// reset release through two flip-flops
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_s1_ff <= 1'b0;
			rst_s2_ff <= 1'b0;
		end else begin
			rst_s1_ff <= 1'b1;
			rst_s2_ff <= rst_s1_ff;
		end
	end

	// instruction fields
	mte_pkg::mte_op_t op;
	logic [5:0]       ma;
	logic [2:0]       bi;
	logic [7:0]       imm;
	logic [7:0]       mv;
	assign op  = mte_pkg::mte_op_t'(st_ff.ir[mte_pkg::OP_HI:mte_pkg::OP_LO]);
	assign ma  = st_ff.ir[mte_pkg::MEM_HI:0];
	assign bi  = st_ff.ir[mte_pkg::BIT_HI:mte_pkg::BIT_LO];
	assign imm = st_ff.ir[mte_pkg::IMM_HI:0];
	// memory operand; low byte of program counter reads through address zero
	assign mv  = (ma == mte_pkg::PCL_ADDR) ? st_ff.pc[7:0] : dmem_ff[ma];

	// next-state logic; work happens on the last clock of each cycle
	always_comb begin
		logic [8:0]  sum;          // wide result for carry and borrow
		logic [7:0]  res;          // byte result
		logic        wr_m;         // write result to memory
		logic        wr_a;         // write result to accumulator
		logic        jump;         // flow change needs extra cycle
		logic        skip;         // skip next instruction
		logic        setz;         // update zero flag
		logic [mte_pkg::PC_W-1:0] tgt;
		logic [mte_pkg::PC_W-1:0] seq;
		sum    = 9'h000;
		res    = mte_pkg::BYTE_ZERO;
		wr_m   = 1'b0;
		wr_a   = 1'b0;
		jump   = 1'b0;
		skip   = 1'b0;
		setz   = 1'b0;
		tgt    = st_ff.ir[mte_pkg::PC_W-1:0];
		seq    = st_ff.pc + 1'b1;
		nxt_st = st_ff;
		dm_we  = 1'b0;
		dm_wa  = ma;
		dm_wd  = mte_pkg::BYTE_ZERO;
		nxt_st.phase  = st_ff.phase + 1'b1;
		nxt_st.strobe = (st_ff.phase == mte_pkg::PH_LAST);
		nxt_st.disc   = 1'b0;
		if (st_ff.phase == mte_pkg::PH_LAST) begin
			unique case (st_ff.st)
				mte_pkg::ST_EXEC: begin
					unique case (op)
						mte_pkg::OP_MOV_MA: begin res = mv; wr_a = 1'b1; end
						mte_pkg::OP_MOV_AM: begin res = st_ff.acc; wr_m = 1'b1; end
						mte_pkg::OP_MOV_XA: begin res = imm; wr_a = 1'b1; end
						mte_pkg::OP_ADD, mte_pkg::OP_ADDX: begin
							sum = {1'b0, st_ff.acc} + {1'b0, (op == mte_pkg::OP_ADD) ? mv : imm};
							res = sum[7:0];
							nxt_st.c = sum[8];
							setz = 1'b1;
							wr_a = 1'b1;
						end
						mte_pkg::OP_SUB, mte_pkg::OP_SUBX: begin
							sum = {1'b0, st_ff.acc} - {1'b0, (op == mte_pkg::OP_SUB) ? mv : imm};
							res = sum[7:0];
							nxt_st.c = ~sum[8];
							setz = 1'b1;
							wr_a = 1'b1;
						end
						mte_pkg::OP_INC, mte_pkg::OP_DEC: begin
							res = (op == mte_pkg::OP_INC) ? mv + mte_pkg::BYTE_ONE
							                              : mv - mte_pkg::BYTE_ONE;
							setz = 1'b1;
							wr_a = st_ff.ir[mte_pkg::DST_BIT];
							wr_m = ~st_ff.ir[mte_pkg::DST_BIT];
						end
						mte_pkg::OP_AND: begin res = st_ff.acc & mv; setz = 1'b1; wr_a = 1'b1; end
						mte_pkg::OP_OR:  begin res = st_ff.acc | mv; setz = 1'b1; wr_a = 1'b1; end
						mte_pkg::OP_XOR: begin res = st_ff.acc ^ mv; setz = 1'b1; wr_a = 1'b1; end
						mte_pkg::OP_CPL: begin
							res = ~mv;
							setz = 1'b1;
							wr_a = st_ff.ir[mte_pkg::DST_BIT];
							wr_m = ~st_ff.ir[mte_pkg::DST_BIT];
						end
						mte_pkg::OP_ROT: begin
							// rotate one position, optionally through carry
							if (st_ff.ir[mte_pkg::ROT_LEFT]) begin
								res = {mv[6:0], st_ff.ir[mte_pkg::ROT_CARY] ? st_ff.c : mv[7]};
								if (st_ff.ir[mte_pkg::ROT_CARY]) nxt_st.c = mv[7];
							end else begin
								res = {st_ff.ir[mte_pkg::ROT_CARY] ? st_ff.c : mv[0], mv[7:1]};
								if (st_ff.ir[mte_pkg::ROT_CARY]) nxt_st.c = mv[0];
							end
							wr_a = st_ff.ir[mte_pkg::DST_BIT];
							wr_m = ~st_ff.ir[mte_pkg::DST_BIT];
						end
						mte_pkg::OP_SZ:   skip = (mv == mte_pkg::BYTE_ZERO);
						mte_pkg::OP_SIZ: begin
							res = mv + mte_pkg::BYTE_ONE; wr_m = 1'b1;
							skip = (res == mte_pkg::BYTE_ZERO);
						end
						mte_pkg::OP_SDZ: begin
							res = mv - mte_pkg::BYTE_ONE; wr_m = 1'b1;
							skip = (res == mte_pkg::BYTE_ZERO);
						end
						mte_pkg::OP_SNZB: skip = mv[bi];
						mte_pkg::OP_SZB:  skip = ~mv[bi];
						mte_pkg::OP_SETB: begin
							res = mv | (mte_pkg::BYTE_ONE << bi); wr_m = 1'b1;
						end
						mte_pkg::OP_CLRB: begin
							res = mv & ~(mte_pkg::BYTE_ONE << bi); wr_m = 1'b1;
						end
						mte_pkg::OP_CLR:  begin res = mte_pkg::BYTE_ZERO; wr_m = 1'b1; end
						mte_pkg::OP_JMP:  jump = 1'b1;
						mte_pkg::OP_CALL: begin
							// push address after the call, which pc already holds
							nxt_st.stk[st_ff.sp*mte_pkg::PC_W +: mte_pkg::PC_W] = st_ff.pc;
							nxt_st.sp = st_ff.sp + 1'b1;
							jump = 1'b1;
						end
						mte_pkg::OP_RET, mte_pkg::OP_IRET: begin
							nxt_st.sp = st_ff.sp - 1'b1;
							tgt = st_ff.stk[nxt_st.sp*mte_pkg::PC_W +: mte_pkg::PC_W];
							jump = 1'b1;
						end
						default: ;
					endcase
					if (setz) nxt_st.z = (res == mte_pkg::BYTE_ZERO);
					if (wr_a) nxt_st.acc = res;
					// write to program counter low byte becomes a jump
					if (wr_m && ma == mte_pkg::PCL_ADDR) begin
						tgt  = {st_ff.pc[mte_pkg::PC_W-1:8], res};
						jump = 1'b1;
					end else if (wr_m) begin
						dm_we = 1'b1;
						dm_wd = res;
					end
					nxt_st.ir = prog_data_i;
					if (op == mte_pkg::OP_TABRD) begin
						// park the pointer; next word is fetched as usual
						nxt_st.st  = mte_pkg::ST_TABLE;
						nxt_st.tbl = imm;
						nxt_st.pc  = seq;
					end else if (jump) begin
						nxt_st.pc = tgt;
						nxt_st.st = mte_pkg::ST_FLUSH;
					end else if (skip) begin
						nxt_st.pc = seq;
						nxt_st.st = mte_pkg::ST_FLUSH;
					end else begin
						nxt_st.pc = seq;
					end
				end
				mte_pkg::ST_FLUSH: begin
					// fetched word is dropped, fetch from new counter
					nxt_st.ir   = prog_data_i;
					nxt_st.pc   = seq;
					nxt_st.disc = 1'b1;
					nxt_st.st   = mte_pkg::ST_EXEC;
				end
				mte_pkg::ST_TABLE: begin
					// table word captured; the held word runs next cycle
					nxt_st.tbl  = prog_data_i[7:0];
					nxt_st.ir   = st_ff.ir;
					nxt_st.st   = mte_pkg::ST_EXEC;
				end
			endcase
		end
	end

	// program address: table pointer during table cycle, else counter
	assign prog_addr_o = (st_ff.st == mte_pkg::ST_TABLE)
	                   ? {st_ff.acc[mte_pkg::PC_W-9:0], st_ff.tbl}
	                   : st_ff.pc;

	// state register
	always_ff @(posedge sys_clk_i or negedge rst_s2_ff) begin
		if (!rst_s2_ff) begin
			st_ff <= '{phase: mte_pkg::PH_FIRST, st: mte_pkg::ST_FLUSH, ir: mte_pkg::NOP_WORD,
			           default: '0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// data memory write port
	always_ff @(posedge sys_clk_i) begin
		if (dm_we) begin
			dmem_ff[dm_wa] <= dm_wd;
		end
	end

	// observation outputs
	assign acc_o          = st_ff.acc;
	assign carry_o        = st_ff.c;
	assign zero_o         = st_ff.z;
	assign pc_o           = st_ff.pc;
	assign cycle_strobe_o = st_ff.strobe;
	assign discard_o      = st_ff.disc;
	assign table_data_o   = st_ff.tbl;
endmodule : mte_core

// ==== core/mte_pkg.sv ====
// Purpose: constants and types for the instruction timing and execution core
// Assumes: 16-bit instruction word with a private encoding, 8-bit data path
// Notes: the instruction encoding below is local to this core
// Functional notes
// - instruction cycle is four system clocks
// - ordinary one cycle; branch, call, table two
// - jump, call, returns, table read add cycle
// - writing program counter low byte jumps, extra
// - skip costs one extra cycle when taken
// - conditional tests memory or bit, skip next
// - three moves: m to A, A to m, immediate
// - add carry above 255, subtract borrow below 0
// - increment and decrement by one, two destinations
// - logic ops via accumulator set zero flag
// - rotate one bit, plain or through carry
// - call returns to address after the call
// - jump loads target, saves no return
// - bit set and clear change one bit only
package mte_pkg;
	localparam int          PC_W        = 11;            // program address width
	localparam int          DM_DEPTH    = 64;            // data memory bytes
	localparam int          DM_AW       = 6;             // data memory address width
	localparam int          STK_DEPTH   = 4;             // return stack levels
	localparam int          STK_AW      = 2;             // stack pointer width
	localparam logic [1:0]  PH_LAST     = 2'h3;          // last clock of an instruction cycle
	localparam logic [1:0]  PH_FIRST    = 2'h0;          // first clock
	localparam logic [5:0]  PCL_ADDR    = 6'h00;         // data address of program counter low byte
	localparam logic [5:0]  ACC_NONE    = 6'h3f;         // unused marker
	localparam logic [7:0]  BYTE_ZERO   = 8'h00;         // zero byte
	localparam logic [7:0]  BYTE_ONE    = 8'h01;         // unit step
	localparam logic [15:0] NOP_WORD    = 16'h0000;      // idle instruction
	// opcode field [15:11]
	typedef enum logic [4:0] {
		OP_NOP   = 5'h00, OP_MOV_MA = 5'h01, OP_MOV_AM = 5'h02, OP_MOV_XA = 5'h03,
		OP_ADD   = 5'h04, OP_ADDX   = 5'h05, OP_SUB    = 5'h06, OP_SUBX   = 5'h07,
		OP_INC   = 5'h08, OP_DEC    = 5'h09, OP_AND    = 5'h0a, OP_OR     = 5'h0b,
		OP_XOR   = 5'h0c, OP_CPL    = 5'h0d, OP_ROT    = 5'h0e, OP_SZ     = 5'h0f,
		OP_SNZB  = 5'h10, OP_SZB    = 5'h11, OP_SETB   = 5'h12, OP_CLRB   = 5'h13,
		OP_JMP   = 5'h14, OP_CALL   = 5'h15, OP_RET    = 5'h16, OP_IRET   = 5'h17,
		OP_TABRD = 5'h18, OP_CLR    = 5'h19, OP_SIZ    = 5'h1a, OP_SDZ    = 5'h1b
	} mte_op_t;
	localparam int OP_HI    = 15;  // opcode top bit
	localparam int OP_LO    = 11;  // opcode low bit
	localparam int DST_BIT  = 10;  // 1: result to accumulator, 0: to memory
	localparam int BIT_HI   = 9;   // bit index top
	localparam int BIT_LO   = 7;   // bit index low
	localparam int ROT_LEFT = 7;   // rotate direction bit
	localparam int ROT_CARY = 6;   // rotate through carry bit
	localparam int MEM_HI   = 5;   // memory address top
	localparam int IMM_HI   = 7;   // immediate top
	// execution sequencer states
	typedef enum logic [2:0] {
		ST_EXEC  = 3'b001, // normal cycle
		ST_FLUSH = 3'b010, // extra cycle, fetched word discarded
		ST_TABLE = 3'b100  // extra cycle of a table read
	} mte_state_t;
endpackage : mte_pkg

// ==== test/mte_core_assertions.sv ====
// Purpose: port checks for the timing and execution core
// Assumes: reset low disables every check
// Notes: visible state may move only together with the cycle strobe
`timescale 1ns/1ps
module mte_core_chk (
	// clock and reset
	input wire logic                     sys_clk_i,
	input wire logic                     rst_b_i,
	// observed outputs
	input wire logic [mte_pkg::PC_W-1:0] prog_addr_o,
	input wire logic [mte_pkg::PC_W-1:0] pc_o,
	input wire logic [7:0]               acc_o,
	input wire logic [7:0]               table_data_o,
	input wire logic                     carry_o,
	input wire logic                     zero_o,
	input wire logic                     cycle_strobe_o,
	input wire logic                     discard_o
);
	// one clock domain for every check
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_b_i);
	// a strobe exactly every fourth clock
	chk_strobe_gap: assert property (
		cycle_strobe_o |=> !cycle_strobe_o [*3] ##1 cycle_strobe_o)
		else $error("strobe spacing is not four clocks");
	// results land only at the end of an instruction cycle
	chk_acc_step: assert property ($changed(acc_o) |-> cycle_strobe_o)
		else $error("accumulator moved off the strobe");
	chk_pc_step: assert property ($changed(pc_o) |-> cycle_strobe_o)
		else $error("program counter moved off the strobe");
	chk_flag_step: assert property ($changed({carry_o, zero_o}) |-> cycle_strobe_o)
		else $error("flags moved off the strobe");
	chk_fetch_step: assert property ($changed(prog_addr_o) |-> cycle_strobe_o)
		else $error("fetch address moved off the strobe");
	chk_table_step: assert property ($changed(table_data_o) |-> cycle_strobe_o)
		else $error("table byte moved off the strobe");
	// a discard marks one clock of one cycle
	chk_discard_once: assert property (discard_o |=> !discard_o [*3])
		else $error("discard pulse too long");
	chk_discard_cycle: assert property (discard_o |-> ##[0:4] cycle_strobe_o)
		else $error("discard outside a cycle");
	// main scenarios reached
	cover property (discard_o);
	cover property ($rose(carry_o));
	cover property ($rose(zero_o));
endmodule : mte_core_chk

// ==== test/tb_mte_core.sv ====
// Purpose: self-checking bench for the timing and execution core
// Assumes: bench plays program memory, answering at the falling edge
// Notes: each run resets the core and loads a program with its operands, bit 0 of the third flipped when it equals the low byte of the first two summed
`timescale 1ns/1ps
module tb_mte_core;
	localparam logic [1:0] DC = 2'h2;          // flag not checked
	logic                        sys_clk_i;
	logic                        rst_b_i;
	logic [mte_pkg::PC_W-1:0]    prog_addr_o;
	logic [15:0]                 prog_data_i;
	logic [7:0]                  acc_o;
	logic                        carry_o;
	logic                        zero_o;
	logic [mte_pkg::PC_W-1:0]    pc_o;
	logic                        cycle_strobe_o;
	logic                        discard_o;
	logic [7:0]                  table_data_o;
	logic [15:0]                 mem [0:63];   // program store
	logic [7:0]                  q_acc [$];    // accumulator per cycle
	logic [1:0]                  q_c [$];      // carry per cycle
	logic [1:0]                  q_z [$];      // zero per cycle
	logic [15:0]                 lfsr_ff;      // random source
	int                          err_count;
	int                          num_checks;
	int                          n_disc;       // discard pulses seen

	mte_core uut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .prog_addr_o(prog_addr_o),
		.prog_data_i(prog_data_i), .acc_o(acc_o), .carry_o(carry_o), .zero_o(zero_o),
		.pc_o(pc_o), .cycle_strobe_o(cycle_strobe_o), .discard_o(discard_o),
		.table_data_o(table_data_o));

	// free running clock
	initial begin
		sys_clk_i = 1'b0;
		forever #2.5 sys_clk_i = ~sys_clk_i;
	end
	// program memory answers off the sampling edge
	always @(negedge sys_clk_i) prog_data_i <= mem[prog_addr_o[5:0]];

	function automatic logic [15:0] lfsr_step(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr_step
	task automatic bad(input string m);
		err_count++;
		$display("FAIL %0t %s", $time, m);
	endtask : bad
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string m);
		num_checks++;
		if (got !== exp) bad(m);
	endtask : cmp8
	task automatic cmpf(input logic got, input logic [1:0] exp, input string m);
		if (exp == DC) return;
		num_checks++;
		if (got !== exp[0]) bad(m);
	endtask : cmpf
	task automatic wrap_up;
		if (err_count == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up
	// place one word and queue its cost in cycles
	task automatic put(input int a, input mte_pkg::mte_op_t op, input logic [10:0] f,
		input int n, input logic [7:0] v, input logic [1:0] c = DC, input logic [1:0] z = DC);
		mem[a] = {op, f};
		repeat (n) begin
			q_acc.push_back(v);
			q_c.push_back(c);
			q_z.push_back(z);
		end
	endtask : put
	// bounded wait for a strobe, counting discards on the way
	task automatic wait_strobe(input int lim, input bit first);
		for (int i = 0; i < lim; i++) begin
			@(negedge sys_clk_i);
			if (!first && discard_o === 1'b1) n_disc++;
			if (cycle_strobe_o === 1'b1 && (!first || acc_o === 8'h01)) return;
		end
		bad("no cycle strobe in time");
		wrap_up();
	endtask : wait_strobe
	// reset, load a program, then compare every cycle
	task automatic run(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
		logic [8:0] s;
		logic [7:0] v;
		logic [7:0] w;
		logic [7:0] r;
		s = a + b;
		if (s[7:0] == c) c = c ^ 8'h01;
		v = s[7:0] - c;
		w = v | 8'h08;
		r = {w[6:0], w[7]};
		@(negedge sys_clk_i);
		rst_b_i = 1'b0;
		q_acc.delete();
		q_c.delete();
		q_z.delete();
		foreach (mem[i]) mem[i] = {mte_pkg::OP_MOV_XA, 11'h077};
		put(0, mte_pkg::OP_MOV_XA, 11'h001, 1, 8'h01);
		put(1, mte_pkg::OP_MOV_XA, {3'h0, a}, 1, a);
		put(2, mte_pkg::OP_ADDX, {3'h0, b}, 1, s[7:0], {1'b0, s[8]});
		put(3, mte_pkg::OP_SUBX, {3'h0, c}, 1, v, {1'b0, s[7:0] >= c});
		put(4, mte_pkg::OP_MOV_AM, 11'h005, 1, v);
		put(5, mte_pkg::OP_INC, 11'h405, 1, v + 8'h01);
		put(6, mte_pkg::OP_JMP, 11'h009, 2, v + 8'h01);
		put(9, mte_pkg::OP_MOV_XA, 11'h002, 1, 8'h02);
		put(10, mte_pkg::OP_CALL, 11'h014, 2, 8'h02);
		put(20, mte_pkg::OP_MOV_XA, 11'h004, 1, 8'h04);
		put(21, mte_pkg::OP_RET, 11'h000, 2, 8'h04);
		put(11, mte_pkg::OP_MOV_XA, 11'h003, 1, 8'h03);
		put(12, mte_pkg::OP_SZ, 11'h005, 1, 8'h03);
		put(13, mte_pkg::OP_MOV_XA, 11'h005, 1, 8'h05);
		put(14, mte_pkg::OP_MOV_XA, 11'h000, 1, 8'h00);
		put(15, mte_pkg::OP_MOV_AM, 11'h006, 1, 8'h00);
		put(16, mte_pkg::OP_SZ, 11'h006, 2, 8'h00);
		put(18, mte_pkg::OP_MOV_XA, 11'h006, 1, 8'h06);
		put(19, mte_pkg::OP_JMP, 11'h018, 2, 8'h06);
		put(24, mte_pkg::OP_SETB, 11'h185, 1, 8'h06);
		put(25, mte_pkg::OP_MOV_MA, 11'h405, 1, w);
		put(26, mte_pkg::OP_ROT, 11'h485, 1, r);
		put(27, mte_pkg::OP_CLRB, 11'h185, 1, r);
		put(28, mte_pkg::OP_XOR, 11'h405, 1, r ^ (v & 8'hf7), DC, {1'b0, r == (v & 8'hf7)});
		put(29, mte_pkg::OP_MOV_XA, 11'h020, 1, 8'h20);
		put(30, mte_pkg::OP_MOV_AM, 11'h000, 2, 8'h20);
		put(32, mte_pkg::OP_MOV_XA, 11'h00a, 1, 8'h0a);
		mem[33] = {mte_pkg::OP_JMP, 11'h021};
		repeat (3) @(negedge sys_clk_i);
		rst_b_i = 1'b1;
		n_disc = 0;
		for (int k = 0; k < q_acc.size(); k++) begin
			wait_strobe(k == 0 ? 300 : 4, k == 0);
			cmp8(acc_o, q_acc[k], "accumulator");
			cmpf(carry_o, q_c[k], "carry");
			cmpf(zero_o, q_z[k], "zero");
		end
		cmp8(8'(n_disc), 8'h06, "discard count");
	endtask : run

	// corner cases first, then random operands
	initial begin
		rst_b_i = 1'b0;
		prog_data_i = 16'h0000;
		err_count = 0;
		num_checks = 0;
		n_disc = 0;
		lfsr_ff = 16'h9b24;
		run(8'hff, 8'h01, 8'h01);
		run(8'h80, 8'h7f, 8'hff);
		repeat (3) begin
			lfsr_ff = lfsr_step(lfsr_ff);
			run(lfsr_ff[7:0] | 8'h80, lfsr_ff[15:8] | 8'h01, lfsr_ff[11:4] | 8'h01);
		end
		wrap_up();
	end
endmodule : tb_mte_core

bind mte_core mte_core_chk u_chk (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
	.prog_addr_o(prog_addr_o), .pc_o(pc_o), .acc_o(acc_o), .table_data_o(table_data_o),
	.carry_o(carry_o), .zero_o(zero_o), .cycle_strobe_o(cycle_strobe_o),
	.discard_o(discard_o));
